// File: hw/tbd_defs.vh
`ifndef TBD_DEFS_VH
`define TBD_DEFS_VH
// control register index; the bus address is the index times four
`define TBD_CTRL_INDEX 8'h36
`define TBD_CTRL_ADDR 10'h0D8
`define TBD_CTRL_RESET 8'h00
`define TBD_BIT_TONE_EN 7
`define TBD_TONE_SEL_HI 6
`define TBD_TONE_SEL_LO 5
`define TBD_BIT_RSVD 4
`define TBD_BIT_TICK_EN 3
`define TBD_TICK_SEL_HI 2
`define TBD_TICK_SEL_LO 0
// second register of our own: bit 0 is the prescaler doubling setting
`define TBD_OPT_ADDR 10'h0DC
`define TBD_PRE_WIDTH 25
`endif

// File: hw/tbd_edge_tap.v
`timescale 1ns/10ps
// picks one prescaler tap and flags its falling edge
module tbd_edge_tap #(
    parameter PRE_W = 25
) (
    mclk,
    rst,
    clkEn,
    prescale,
    tapIndex,
    tapLevel,
    tapFall
);
    input wire mclk;
    input wire rst;
    input wire clkEn;
    input wire [PRE_W-1:0] prescale;
    input wire [4:0] tapIndex;
    output wire tapLevel;
    output wire tapFall;

    reg prevTap_ff;
    reg [4:0] prevIdx_ff;

    assign tapLevel = prescale[tapIndex];
    // a tap switch is no edge: without the index match a new rate would fake one
    assign tapFall = prevTap_ff & ~tapLevel & (prevIdx_ff == tapIndex);

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            prevTap_ff <= 1'b0;
            prevIdx_ff <= 5'h00;
        end
        else if (clkEn)
        begin
            prevTap_ff <= tapLevel;
            prevIdx_ff <= tapIndex;
        end
    end
endmodule

// File: hw/tbd_tick_tone.v
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "tbd_defs.vh"
// How it works
// R1 - interrupt on every tap falling edge once enabled
// R2 - prescaler runs free, software cannot clear it
// R3 - software changes tick rate only while disabled
// R4 - one write may set rate and enable
// R5 - tick rate clock/2^n, n 23..9, doubled +1
// R6 - bit 4 reserved, reads zero
// R7 - tone pin square wave, 50% duty
// R8 - tone rate clock/2^n, n 13..10, doubled +1
// R9 - tone enable read/write, resets off
// R10 - software changes tone rate only while off
// R11 - software presets port latch before output mode
// R12 - tone pin rests high while disabled
module tbd_tick_tone #(
    parameter PRE_W = `TBD_PRE_WIDTH
) (
    mclk,
    rst,
    clkEn,
    wb_adr_i,
    wb_dat_i,
    wb_dat_o,
    wb_sel_i,
    wb_we_i,
    wb_cyc_i,
    wb_stb_i,
    wb_ack_o,
    tickInterrupt,
    toneOutN
);
    input wire mclk;
    input wire rst;
    input wire clkEn;
    input wire [9:0] wb_adr_i;
    input wire [31:0] wb_dat_i;
    output reg [31:0] wb_dat_o;
    input wire [3:0] wb_sel_i;
    input wire wb_we_i;
    input wire wb_cyc_i;
    input wire wb_stb_i;
    output reg wb_ack_o;
    output reg tickInterrupt;
    output reg toneOutN;

    reg [PRE_W-1:0] prescale_ff;
    reg [7:0] ctrl_ff;
    reg dbl_ff;
    reg [4:0] tickTap;
    reg [4:0] toneTap;
    wire tickLevel;
    wire tickFall;
    wire toneLevel;
    wire reqHit;
    wire wrCtrl;
    wire wrOpt;
    wire rdReq;
    wire tickEn;
    wire toneEn;

    assign tickEn = ctrl_ff[`TBD_BIT_TICK_EN];
    assign toneEn = ctrl_ff[`TBD_BIT_TONE_EN];
    assign reqHit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrCtrl = reqHit & wb_we_i & wb_sel_i[0] & (wb_adr_i == `TBD_CTRL_ADDR);
    assign wrOpt = reqHit & wb_we_i & wb_sel_i[0] & (wb_adr_i == `TBD_OPT_ADDR);
    assign rdReq = reqHit & ~wb_we_i;

    // tap n of clock/2^n is prescaler bit n-1
    always @*
    begin
        case (ctrl_ff[`TBD_TICK_SEL_HI:`TBD_TICK_SEL_LO]) // R5
            3'h0: tickTap = 5'h16;
            3'h1: tickTap = 5'h14;
            3'h2: tickTap = 5'h0F;
            3'h3: tickTap = 5'h0D;
            3'h4: tickTap = 5'h0C;
            3'h5: tickTap = 5'h0B;
            3'h6: tickTap = 5'h0A;
            default: tickTap = 5'h08;
        endcase
        // doubling moves every tap one bit up, halving each rate
        if (dbl_ff)
            tickTap = tickTap + 5'h01;
    end

    // the tone taps 9..12 sit inside the tick tap range 8..22, each one higher when doubled
    always @*
    begin
        case (ctrl_ff[`TBD_TONE_SEL_HI:`TBD_TONE_SEL_LO]) // R8
            2'h0: toneTap = 5'h0C;
            2'h1: toneTap = 5'h0B;
            2'h2: toneTap = 5'h0A;
            default: toneTap = 5'h09;
        endcase
        if (dbl_ff)
            toneTap = toneTap + 5'h01;
    end

    tbd_edge_tap #(.PRE_W(PRE_W)) uTick (
        .mclk(mclk),
        .rst(rst),
        .clkEn(clkEn),
        .prescale(prescale_ff),
        .tapIndex(tickTap),
        .tapLevel(tickLevel),
        .tapFall(tickFall)
    );

    tbd_edge_tap #(.PRE_W(PRE_W)) uTone (
        .mclk(mclk),
        .rst(rst),
        .clkEn(clkEn),
        .prescale(prescale_ff),
        .tapIndex(toneTap),
        .tapLevel(toneLevel),
        .tapFall()
    );

    // free-running prescaler shared by both taps
    // no register path touches it, so the first tick after enable may come early
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            prescale_ff <= {PRE_W{1'b0}};
        end
        else if (clkEn)
        begin
            prescale_ff <= prescale_ff + {{(PRE_W-1){1'b0}}, 1'b1}; // R2
        end
    end

    // bus answer: ack one cycle after the request is taken, for one cycle
    // the ~ack term in reqHit keeps a held request from being taken twice
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
        end
        else if (clkEn)
        begin
            wb_ack_o <= reqHit;
        end
    end

    // control byte; bit 4 is forced to zero whatever software writes
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_ff <= `TBD_CTRL_RESET;
        end
        else if (clkEn && wrCtrl)
        begin
            // rate and enable land together, so the new rate rules from enable on
            ctrl_ff <= wb_dat_i[7:0] & 8'hEF; // R4 R6 R9
        end
    end

    // doubling option lives in its own word
    // changing it while a tap is in use gives one short or long period
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            dbl_ff <= 1'b0;
        end
        else if (clkEn && wrOpt)
        begin
            dbl_ff <= wb_dat_i[0];
        end
    end

    // read data is captured at the taking edge and held until the next read
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wb_dat_o <= 32'h00000000;
        end
        else if (clkEn && rdReq)
        begin
            case (wb_adr_i)
                `TBD_CTRL_ADDR: wb_dat_o <= {24'h000000, ctrl_ff};
                `TBD_OPT_ADDR: wb_dat_o <= {31'h00000000, dbl_ff};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // one-cycle pulse per falling edge of the selected tap
    // the edge detector keeps running while disabled, so a fall right at
    // enable is reported at once
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tickInterrupt <= 1'b0;
        end
        else if (clkEn)
        begin
            tickInterrupt <= tickEn & tickFall; // R1
        end
    end

    // active-low pin: low half of the wave when the tap is high
    // the registered pin costs one cycle of lag but keeps it glitch free
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            toneOutN <= 1'b1;
        end
        else if (clkEn)
        begin
            toneOutN <= toneEn ? ~toneLevel : 1'b1; // R7 R12
        end
    end
endmodule

// File: test/tbd_tick_tone_sva.sv
`timescale 1ns/10ps
`include "tbd_defs.vh"
module tbd_tick_tone_sva (
    input wire logic mclk, rst, clkEn, wb_we_i, wb_cyc_i, wb_stb_i,
    input wire logic wb_ack_o, tickInterrupt, toneOutN,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i, wb_dat_o,
    input wire logic [3:0] wb_sel_i
);
    logic [7:0] ctrl_ff;
    logic rd, take;
    assign rd = wb_ack_o && !wb_we_i;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
    always @(posedge mclk or posedge rst)
        if (rst)
            ctrl_ff <= 8'h00;
        else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == `TBD_CTRL_ADDR)
            ctrl_ff <= wb_dat_i[7:0] & 8'hEF;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_ack_answer: assert property (take |=> wb_ack_o) else $error("no ack");
    chk_ack_pulse: assert property (wb_ack_o && clkEn |=> !wb_ack_o) else $error("long ack");
    chk_ctrl_read: assert property (rd && wb_adr_i == `TBD_CTRL_ADDR
        |-> wb_dat_o == {24'h0, ctrl_ff}) else $error("ctrl read");
    chk_unmapped_zero: assert property (rd && wb_adr_i != `TBD_CTRL_ADDR
        && wb_adr_i != `TBD_OPT_ADDR |-> wb_dat_o == 32'h0) else $error("unmapped");
    chk_tone_idle: assert property (!ctrl_ff[7] && !$past(ctrl_ff[7]) |-> toneOutN)
        else $error("tone idle");
    chk_tick_enable: assert property (tickInterrupt |-> ctrl_ff[3] || $past(ctrl_ff[3]))
        else $error("tick off");
    chk_tick_gap: assert property (tickInterrupt |=> !tickInterrupt [*8])
        else $error("tick gap");
endmodule

// File: test/tbd_buzz_load.sv
`timescale 1ns/10ps
module tbd_buzz_load (
    input wire logic mclk,
    input wire logic toneOutN,
    output int period,
    output int lowLen
);
    int n = 0;
    int l = 0;
    logic p = 1'h1;
    // a load only sees edges, so the period is taken between falling edges
    always @(posedge mclk)
    begin
        p <= toneOutN;
        n <= (p && !toneOutN) ? 1 : n + 1;
        l <= toneOutN ? 0 : l + 1;
        if (p && !toneOutN)
            period <= n;
        if (!p && toneOutN)
            lowLen <= l;
    end
endmodule

// File: test/test_tbd_tick_tone.sv
`timescale 1ns/10ps
`include "tbd_defs.vh"
module test_tbd_tick_tone;
    logic mclk = 1'h0, rst = 1'h1, clkEn = 1'h1, we = 1'h0, cyc = 1'h0, stb = 1'h0;
    logic ack, tick, toneOutN;
    logic [9:0] adr = 10'h0;
    logic [31:0] wdat = 32'h0, r, rdat;
    int num_errors = 0, n_compared = 0, period, lowLen, g;
    tbd_tick_tone tbd_tick_tone_inst (.mclk(mclk), .rst(rst), .clkEn(clkEn), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack), .tickInterrupt(tick), .toneOutN(toneOutN));
    tbd_buzz_load tbd_buzz_load_inst (.mclk(mclk), .toneOutN(toneOutN), .period(period),
        .lowLen(lowLen));
    initial forever #12.5 mclk = ~mclk;
    task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge mclk);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
        do @(posedge mclk); while (ack !== 1'h1);
        r = rdat;
        {cyc, stb, we} <= 3'h0;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task gap(output int c);
        c = 0;
        do @(posedge mclk); while (tick !== 1'h1);
        do begin @(posedge mclk); c++; end while (tick !== 1'h1);
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge mclk);
        rst <= 1'h0;
        bus(1'h0, `TBD_CTRL_ADDR, 32'h0);
        cmp(r, 32'h0);
        bus(1'h0, 10'h0E0, 32'h0);
        cmp(r, 32'h0);
        bus(1'h1, `TBD_CTRL_ADDR, 32'hFF);
        bus(1'h0, `TBD_CTRL_ADDR, 32'h0);
        cmp(r, 32'hEF);
        $display("register test done");
        gap(g);
        cmp(g, 32'h200);
        repeat (3000) @(posedge mclk);
        cmp(period, 32'h400);
        cmp(lowLen, 32'h200);
        bus(1'h1, `TBD_CTRL_ADDR, 32'h67);
        repeat (600) @(posedge mclk);
        cmp(toneOutN, 32'h1);
        bus(1'h1, `TBD_OPT_ADDR, 32'h1);
        bus(1'h1, `TBD_CTRL_ADDR, 32'hEF);
        gap(g);
        cmp(g, 32'h400);
        repeat (6000) @(posedge mclk);
        cmp(period, 32'h800);
        $display("rate test done");
        print_verdict;
    end
    initial
    begin
        #1ms;
        num_errors++;
        print_verdict;
    end
endmodule
bind tbd_tick_tone tbd_tick_tone_sva tbd_tick_tone_sva_inst (.*);
